/* File: src/tws_pkg.sv */
// package: register map, field positions and types for the two-wire slave
// How it works
// - 7-bit: address bits match shift bits 7..1
// - sample data on clock rising edge
// - idle until start, then shift 8 bits
// - match: ack, event flag at ninth fall
// - address byte never loads receive buffer
// - read address: ack, stretch until release
// - transmit data changes after falling clock
// - transmit event pulse regardless of master ack
// - write address: receive, load buffer, ack
// - buffer full: no ack, no load, pulse
// - overflow without full: load but nack
// - receive double buffered, transmit single buffered
// - control bit ten selects 10-bit addressing
// - 10-bit first byte 11110 plus top bits
// - first byte write: pulse, clear full-match
// - second byte matches low eight, set full-match
// - after full match, restart read needs first byte
// - ack with empty transmit: clear release, stretch
// - transmit stretching ignores receive stretch enable
// - transmit loaded early: no stretch
// - release write works whatever transmit state
// - receive stretch enable holds clock after byte
// - stretch enable and full: clear release
package tws_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] TWS_OFF_CTRL = 8'h00;
   localparam logic [7:0] TWS_OFF_STAT = 8'h04;
   localparam logic [7:0] TWS_OFF_ADDR = 8'h08;
   localparam logic [7:0] TWS_OFF_TX = 8'h0c;
   localparam logic [7:0] TWS_OFF_RX = 8'h10;
   // control field positions
   localparam int TWS_C_ON = 15;
   localparam int TWS_C_REL = 12;
   localparam int TWS_C_A10 = 10;
   localparam int TWS_C_STR = 6;
   // status field positions
   localparam int TWS_S_OV = 6;
   localparam int TWS_S_FULL10 = 8;
   localparam int TWS_S_RW = 2;
   localparam int TWS_S_RBF = 1;
   localparam int TWS_S_TBF = 0;
   localparam logic [4:0] TWS_TEN_PAT = 5'h1e;
   localparam logic [3:0] TWS_BITS = 4'h8;
   // slave protocol states
   typedef enum logic [2:0]
   {
      TWS_IDLE = 3'b000,
      TWS_ADDR1 = 3'b001,
      TWS_ADDR2 = 3'b010,
      TWS_RX = 3'b011,
      TWS_TX = 3'b100
   } tws_state_t;
   // apb request bundle
   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } tws_apb_req_t;
   // open-drain pin bundle, output is always low
   typedef struct packed
   {
      logic scl_oe;
      logic sda_oe;
   } tws_pins_t;
endpackage

/* File: src/tws_slave.sv */
// two-wire slave with address match, double-buffered receive and stretching
//
// Implementation choices: the placing of the registers and the APB register port.
module tws_slave
(
   input wire logic pclk,
   input wire logic presetn,
   input wire tws_pkg::tws_apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o,
   output tws_pkg::tws_pins_t pins,
   output logic slave_event
);
   import tws_pkg::*;

   // two-flop synchronisers for the bus lines
   logic [1:0] scl_s_q;
   logic [1:0] sda_s_q;
   logic scl_p_q; // previous synced clock
   logic sda_p_q; // previous synced data
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   // registers
   logic module_on_q;
   logic clock_release_q;
   logic ten_bit_addr_select_q;
   logic rx_stretch_enable_q;
   logic [9:0] slave_address_reg_q;
   logic [7:0] tx_data_reg_q;
   logic [7:0] rx_buffer_reg_q;
   logic [7:0] rx_shift_reg_q;
   logic tx_full_flag_q;
   logic rx_full_flag_q;
   logic rx_overflow_flag_q;
   logic ten_bit_full_match_q;
   logic rw_q; // direction of current transfer

   // protocol engine
   tws_state_t state_q;
   logic [3:0] bit_cnt_q; // bits shifted so far, 8 means ack slot
   logic ack_q; // pulling data low for ack
   logic tx_drive_q; // pulling data low for a zero data bit
   logic [7:0] tx_sh_q; // transmit shift
   logic mst_ack_q; // ack seen from master
   logic hold_q; // pulling clock low
   logic ev_q; // slave event pulse

   // apb decode
   logic wr_en;
   logic rd_en;
   logic rx_read;
   logic tx_write;
   logic rel_write;
   assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
   assign rx_read = rd_en & (apb_req.paddr == TWS_OFF_RX);
   assign tx_write = wr_en & (apb_req.paddr == TWS_OFF_TX);
   assign rel_write = wr_en & (apb_req.paddr == TWS_OFF_CTRL)
                      & apb_req.pwdata[TWS_C_REL];
   assign pready = 1'b1;

   // unmapped addresses answer with an error
   always_comb
   begin
      unique case (apb_req.paddr)
         TWS_OFF_CTRL, TWS_OFF_STAT, TWS_OFF_ADDR, TWS_OFF_TX, TWS_OFF_RX:
            pslverr = 1'b0;
         default:
            pslverr = apb_req.psel & apb_req.penable;
      endcase
   end

   // synchronise pins and keep one more stage for edge finding
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         scl_s_q <= {scl_s_q[0], scl_i};
         sda_s_q <= {sda_s_q[0], sda_i};
         scl_p_q <= scl_s_q[1];
         sda_p_q <= sda_s_q[1];
      end
   end
   assign scl_rise = scl_s_q[1] & ~scl_p_q;
   assign scl_fall = ~scl_s_q[1] & scl_p_q;
   assign start_det = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
   assign stop_det = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];

   // address matching on the completed shift byte
   logic [7:0] byte_in;
   logic match7;
   logic match10a;
   logic match10b;
   logic end9;
   assign byte_in = rx_shift_reg_q;
   assign match7 = (byte_in[7:1] == slave_address_reg_q[6:0]);
   assign match10a = (byte_in[7:3] == TWS_TEN_PAT)
                     && (byte_in[2:1] == slave_address_reg_q[9:8]);
   assign match10b = (byte_in == slave_address_reg_q[7:0]);
   assign end9 = scl_fall & (bit_cnt_q == TWS_BITS + 4'h1);

   // software registers: control, address, transmit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         module_on_q <= 1'b0;
         ten_bit_addr_select_q <= 1'b0;
         rx_stretch_enable_q <= 1'b0;
         slave_address_reg_q <= 10'h000;
         tx_data_reg_q <= 8'h00;
      end
      else if (wr_en)
      begin
         if (apb_req.paddr == TWS_OFF_CTRL)
         begin
            module_on_q <= apb_req.pwdata[TWS_C_ON];
            ten_bit_addr_select_q <= apb_req.pwdata[TWS_C_A10];
            rx_stretch_enable_q <= apb_req.pwdata[TWS_C_STR];
         end
         if (apb_req.paddr == TWS_OFF_ADDR)
            slave_address_reg_q <= apb_req.pwdata[9:0];
         if (tx_write)
            tx_data_reg_q <= apb_req.pwdata[7:0]; // single buffered
      end
   end

   // transmit full flag: set by write, cleared when loaded into the shifter
   logic tx_load;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tx_full_flag_q <= 1'b0;
      else if (tx_write)
         tx_full_flag_q <= 1'b1;
      else if (tx_load)
         tx_full_flag_q <= 1'b0;
   end

   // clock release bit: cleared by hardware at the ninth fall, set by software
   logic rel_clear;
   assign rel_clear = end9 & (((state_q == TWS_TX) & mst_ack_q & ~tx_full_flag_q)
                      | ((state_q == TWS_ADDR1) & ack_q & rw_q & ~tx_full_flag_q)
                      | ((state_q == TWS_RX) & rx_stretch_enable_q & rx_full_flag_q));
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clock_release_q <= 1'b1;
      else if (rel_write)
         clock_release_q <= 1'b1; // set wins, any transmit state
      else if (rel_clear)
         clock_release_q <= 1'b0;
   end

   // shift in bits on each rising clock until eight are counted
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rx_shift_reg_q <= 8'h00;
      else if (scl_rise && bit_cnt_q < TWS_BITS)
         rx_shift_reg_q <= {rx_shift_reg_q[6:0], sda_s_q[1]};
   end

   // byte completion (8th rising edge done, at 8th fall)
   logic byte_done;
   logic rx_load;
   assign byte_done = scl_fall & (bit_cnt_q == TWS_BITS);
   assign rx_load = byte_done & (state_q == TWS_RX) & ~rx_full_flag_q;

   // receive buffer and flags; addresses never load it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_buffer_reg_q <= 8'h00;
         rx_full_flag_q <= 1'b0;
         rx_overflow_flag_q <= 1'b0;
      end
      else
      begin
         if (rx_load)
            rx_buffer_reg_q <= rx_shift_reg_q;
         if (rx_load)
            rx_full_flag_q <= 1'b1;
         else if (rx_read)
            rx_full_flag_q <= 1'b0;
         if (byte_done && state_q == TWS_RX && rx_full_flag_q)
            rx_overflow_flag_q <= 1'b1; // overflow wins over clear
         else if (wr_en && apb_req.paddr == TWS_OFF_STAT)
            rx_overflow_flag_q <= apb_req.pwdata[TWS_S_OV];
      end
   end

   // protocol state machine, advanced on clock edges
   // transmit byte enters the shifter while the clock is low, before its first bit is due
   assign tx_load = (state_q == TWS_TX) & (bit_cnt_q == 4'h0) & tx_full_flag_q & ~scl_s_q[1];
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= TWS_IDLE;
         bit_cnt_q <= 4'h0;
         ack_q <= 1'b0;
         rw_q <= 1'b0;
         ten_bit_full_match_q <= 1'b0;
         mst_ack_q <= 1'b0;
         ev_q <= 1'b0;
      end
      else
      begin
         ev_q <= 1'b0;
         if (!module_on_q || stop_det)
         begin
            state_q <= TWS_IDLE; // idle until start
            bit_cnt_q <= 4'h0;
            ack_q <= 1'b0;
         end
         else if (start_det)
         begin
            state_q <= TWS_ADDR1;
            bit_cnt_q <= 4'h0;
            ack_q <= 1'b0;
         end
         else if (state_q != TWS_IDLE)
         begin
            // bits count on rising clock, so the fall that follows a start is not a bit
            if (scl_rise && bit_cnt_q <= TWS_BITS)
               bit_cnt_q <= bit_cnt_q + 4'h1;
            if (scl_rise && bit_cnt_q == TWS_BITS && state_q == TWS_TX)
               mst_ack_q <= ~sda_s_q[1];
            if (scl_fall)
            begin
               // fall after the eighth bit opens the acknowledge slot
               if (bit_cnt_q == TWS_BITS)
               begin
                  unique case (state_q)
                     TWS_ADDR1:
                     begin
                        rw_q <= byte_in[0];
                        if (!ten_bit_addr_select_q)
                           ack_q <= match7;
                        else if (byte_in[0])
                           ack_q <= match10a & ten_bit_full_match_q;
                        else
                           ack_q <= match10a;
                     end
                     TWS_ADDR2: ack_q <= match10b;
                     TWS_RX: ack_q <= ~rx_full_flag_q & ~rx_overflow_flag_q;
                     TWS_TX: ack_q <= 1'b0;
                     default: ack_q <= 1'b0;
                  endcase
               end
               else if (bit_cnt_q == TWS_BITS + 4'h1)
               begin
                  bit_cnt_q <= 4'h0;
                  ack_q <= 1'b0;
                  unique case (state_q)
                     TWS_ADDR1:
                     begin
                        ev_q <= ack_q;
                        if (!ack_q)
                        begin
                           state_q <= TWS_IDLE;
                           ten_bit_full_match_q <= 1'b0;
                        end
                        else if (ten_bit_addr_select_q && !rw_q)
                        begin
                           state_q <= TWS_ADDR2;
                           ten_bit_full_match_q <= 1'b0; // partial match
                        end
                        else
                           state_q <= rw_q ? TWS_TX : TWS_RX;
                     end
                     TWS_ADDR2:
                     begin
                        ev_q <= ack_q;
                        ten_bit_full_match_q <= ack_q;
                        state_q <= ack_q ? TWS_RX : TWS_IDLE;
                     end
                     TWS_TX:
                     begin
                        ev_q <= 1'b1;
                        if (!mst_ack_q)
                           state_q <= TWS_IDLE;
                     end
                     default: ev_q <= 1'b1; // receive byte event
                  endcase
               end
            end
         end
      end
   end

   // transmit shifter: loaded then shifted after each falling clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_sh_q <= 8'hff;
         tx_drive_q <= 1'b0;
      end
      else if (tx_load)
      begin
         tx_sh_q <= {tx_data_reg_q[6:0], 1'b1};
         tx_drive_q <= ~tx_data_reg_q[7];
      end
      else if (state_q == TWS_TX && scl_fall && bit_cnt_q < TWS_BITS)
      begin
         tx_drive_q <= ~tx_sh_q[7];
         tx_sh_q <= {tx_sh_q[6:0], 1'b1};
      end
      else if (scl_fall || state_q != TWS_TX)
         tx_drive_q <= 1'b0; // release for master ack, or once transmit is left
   end

   // clock hold: once the line is low and release is clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hold_q <= 1'b0;
      else
         hold_q <= module_on_q & ~clock_release_q & ~scl_s_q[1] | (hold_q & ~clock_release_q);
   end

   // pins: outputs always low, enables pull the line
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign pins = '{scl_oe: hold_q, sda_oe: ack_q | tx_drive_q};
   assign slave_event = ev_q;

   // read data from a flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0;
      else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
      begin
         prdata <= 32'h0;
         unique case (apb_req.paddr)
            TWS_OFF_CTRL:
            begin
               prdata[TWS_C_ON] <= module_on_q;
               prdata[TWS_C_REL] <= clock_release_q;
               prdata[TWS_C_A10] <= ten_bit_addr_select_q;
               prdata[TWS_C_STR] <= rx_stretch_enable_q;
            end
            TWS_OFF_STAT:
            begin
               prdata[TWS_S_FULL10] <= ten_bit_full_match_q;
               prdata[TWS_S_OV] <= rx_overflow_flag_q;
               prdata[TWS_S_RW] <= rw_q;
               prdata[TWS_S_RBF] <= rx_full_flag_q;
               prdata[TWS_S_TBF] <= tx_full_flag_q;
            end
            TWS_OFF_ADDR: prdata[9:0] <= slave_address_reg_q;
            TWS_OFF_TX: prdata[7:0] <= tx_data_reg_q;
            TWS_OFF_RX: prdata[7:0] <= rx_buffer_reg_q;
            default: prdata <= 32'h0;
         endcase
      end
   end

   // assertions
   a_never_drive_high: assert property (@(posedge pclk) disable iff (!presetn)
      !scl_o && !sda_o) else $error("line driven high");
   a_full_no_load: assert property (@(posedge pclk) disable iff (!presetn)
      (byte_done && state_q == TWS_RX && rx_full_flag_q && !rx_read)
      |=> $stable(rx_buffer_reg_q)) else $error("full buffer overwritten");
   a_rx_ack_rule: assert property (@(posedge pclk) disable iff (!presetn)
      (scl_fall && bit_cnt_q == TWS_BITS && state_q == TWS_RX && rx_overflow_flag_q)
      |=> !ack_q) else $error("ack during overflow");
   a_tx_stretch: assert property (@(posedge pclk) disable iff (!presetn)
      (end9 && state_q == TWS_TX && mst_ack_q && !tx_full_flag_q && !rel_write)
      |=> !clock_release_q) else $error("release not cleared");
   a_tx_nostretch: assert property (@(posedge pclk) disable iff (!presetn)
      (end9 && state_q == TWS_TX && clock_release_q && tx_full_flag_q)
      |=> clock_release_q) else $error("stretch with full tx");
   a_release_set: assert property (@(posedge pclk) disable iff (!presetn)
      rel_write |=> clock_release_q) else $error("release write lost");
   a_addr_no_buf: assert property (@(posedge pclk) disable iff (!presetn)
      (byte_done && state_q == TWS_ADDR1) |=> $stable(rx_full_flag_q) || $past(rx_read))
      else $error("address touched buffer");
   a_tx_event: assert property (@(posedge pclk) disable iff (!presetn && 1'b1)
      (end9 && state_q == TWS_TX && module_on_q && !start_det && !stop_det)
      |=> ev_q) else $error("missing tx event");
   c_rx_byte: cover property (@(posedge pclk) rx_load);
   c_tx_load: cover property (@(posedge pclk) tx_load);
   c_stretch: cover property (@(posedge pclk) hold_q);
endmodule

/* File: dv/tws_master.sv */
// behavioural two-wire bus master with a 125 ns bit time and stretch detection
module tws_master
(
   input wire logic scl_line,
   input wire logic sda_line,
   output logic scl_pull,
   output logic sda_pull,
   output int n_stretch,
   output logic hang
);
   timeunit 1ns;
   timeprecision 100ps;
   // quarter of the 125 ns bit time
   localparam realtime QTR = 31.25;
   // both lines released at time zero, so the pull-ups show high
   initial
   begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      n_stretch = 0;
      hang = 1'b0;
   end
   // release the clock, then wait (bounded) while the slave holds it low
   task automatic rise();
      int n;
      begin
         n = 0;
         scl_pull = 1'b0;
         #1;
         while (scl_line !== 1'b1 && n < 30000)
         begin
            #10;
            n++;
         end
         if (n > 5)
            n_stretch++;
         if (n >= 30000)
            hang = 1'b1;
         #QTR;
      end
   endtask
   // one bit: data set mid low phase, sampled mid high phase
   task automatic bit_io(input logic b, output logic s);
      begin
         #QTR;
         sda_pull = ~b;
         #QTR;
         rise();
         s = sda_line;
         #QTR;
         scl_pull = 1'b1;
      end
   endtask
   // start or repeated start: data falls while the clock is high
   task automatic start();
      begin
         #QTR;
         sda_pull = 1'b0;
         #QTR;
         rise();
         sda_pull = 1'b1;
         #QTR;
         scl_pull = 1'b1;
      end
   endtask
   // stop: data rises while the clock is high, both left released
   task automatic stop();
      begin
         #QTR;
         sda_pull = 1'b1;
         #QTR;
         rise();
         sda_pull = 1'b0;
         #QTR;
      end
   endtask
   // send a byte msb first, return the slave's acknowledge level
   task automatic wr_byte(input logic [7:0] d, output logic ack_n);
      logic s;
      begin
         for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
         bit_io(1'b1, ack_n);
      end
   endtask
   // read a byte msb first, then drive the given acknowledge level
   task automatic rd_byte(output logic [7:0] d, input logic ack_n);
      logic s;
      begin
         for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
         bit_io(ack_n, s);
      end
   endtask
endmodule

/* File: dv/tws_slave_tb.sv */
// testbench: apb software, bus master model and a model of the slave's buffers
module tws_slave_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import tws_pkg::*;
   localparam logic [31:0] CTL_ON = (32'h1 << TWS_C_ON) | (32'h1 << TWS_C_REL);
   localparam logic [31:0] CTL_STR = CTL_ON | (32'h1 << TWS_C_STR);
   localparam logic [31:0] CTL_TEN = CTL_ON | (32'h1 << TWS_C_A10);
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   tws_apb_req_t req = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic scl_o;
   logic sda_o;
   logic slave_event;
   tws_pins_t pins;
   logic m_scl;
   logic m_sda;
   wire scl_line;
   wire sda_line;
   int m_str;
   logic m_hang;
   int n_errors = 0;
   int tests_run = 0;
   int n_ev = 0; // event pulses seen
   int e_ev = 0; // event pulses expected
   int seed = 32'h4240;
   int s0;
   logic m_rbf = 1'b0; // model: receive buffer full
   logic m_ov = 1'b0; // model: overflow
   logic m_f10 = 1'b0; // model: full ten-bit match
   logic [7:0] m_rx; // model: receive buffer
   logic [31:0] v;
   logic err;
   logic ak;
   logic [6:0] a7;
   logic [9:0] a10;
   logic [7:0] d;
   logic [7:0] r;
   // open-drain lines with pull-ups
   assign scl_line = ~(m_scl | pins.scl_oe);
   assign sda_line = ~(m_sda | pins.sda_oe);
   always #5 pclk = ~pclk;
   // count event pulses
   always @(posedge pclk)
   begin
      if (slave_event === 1'b1)
         n_ev <= n_ev + 1;
   end
   tws_slave u_tws_slave (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_i(scl_line), .sda_i(sda_line), .scl_o(scl_o),
      .sda_o(sda_o), .pins(pins), .slave_event(slave_event));
   tws_master u_tws_master (.scl_line(scl_line), .sda_line(sda_line), .scl_pull(m_scl),
      .sda_pull(m_sda), .n_stretch(m_str), .hang(m_hang));
   // verdict and end of run
   task automatic finish_test();
      begin
         if (m_hang !== 1'b0)
            n_errors++;
         $display("comparisons %0d mismatches %0d", tests_run, n_errors);
         if (n_errors == 0 && tests_run > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // compare seen with expected
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      begin
         tests_run++;
         if (got !== exp)
         begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // one apb transfer; read data and error land in v and err
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      begin
         n = 0;
         @(posedge pclk);
         req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
         @(posedge pclk);
         req.penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1 && n < 50)
         begin
            @(posedge pclk);
            n++;
         end
         v = prdata;
         err = pslverr;
         req.psel <= 1'b0;
         req.penable <= 1'b0;
         if (n >= 50)
         begin
            n_errors++;
            finish_test();
         end
      end
   endtask
   // event pulses after the last byte
   task automatic evt(input int k);
      begin
         repeat (8) @(posedge pclk);
         e_ev += k;
         check(n_ev, e_ev);
      end
   endtask
   // status flags against the model
   task automatic stat();
      begin
         apb(1'b0, TWS_OFF_STAT, 32'h0);
         check(v & 32'h142, (32'(m_f10) << TWS_S_FULL10) | (32'(m_ov) << TWS_S_OV)
            | (32'(m_rbf) << TWS_S_RBF));
      end
   endtask
   // read the receive buffer
   task automatic pop();
      begin
         apb(1'b0, TWS_OFF_RX, 32'h0);
         check(v[7:0], m_rx);
         m_rbf = 1'b0;
      end
   endtask
   // master sends a random data byte; model the buffer and acknowledge
   task automatic put();
      begin
         d = 8'($random(seed));
         u_tws_master.wr_byte(d, ak);
         check(ak, m_rbf | m_ov);
         if (!m_rbf)
            m_rx = d;
         m_ov = m_ov | m_rbf;
         m_rbf = 1'b1;
         evt(1);
         stat();
      end
   endtask
   // software answers a stretched clock
   task automatic serve(input logic tx, input logic [31:0] ctl);
      begin
         repeat (40) @(posedge pclk);
         check(pins.scl_oe, 1'b1);
         if (tx)
            apb(1'b1, TWS_OFF_TX, {24'h0, d});
         else
            pop();
         apb(1'b1, TWS_OFF_CTRL, ctl);
      end
   endtask
   // watchdog against a hang
   initial
   begin
      #900us;
      n_errors++;
      finish_test();
   end
   // main sequence
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, TWS_OFF_CTRL, 32'h0);
      check(v, 32'h1 << TWS_C_REL);
      apb(1'b0, 8'h20, 32'h0);
      check(err, 1'b1);
      check(v, 32'h0);
      $display("test registers done");
      a7 = 7'h20 + 7'($random(seed) & 31);
      apb(1'b1, TWS_OFF_ADDR, {25'h0, a7});
      apb(1'b1, TWS_OFF_CTRL, CTL_ON);
      u_tws_master.start();
      u_tws_master.wr_byte({a7, 1'b0}, ak);
      check(ak, 1'b0);
      evt(1);
      stat();
      put();
      put();
      pop();
      put();
      pop();
      m_ov = 1'b0;
      apb(1'b1, TWS_OFF_STAT, 32'h0);
      stat();
      u_tws_master.stop();
      u_tws_master.start();
      u_tws_master.wr_byte({a7 ^ 7'h01, 1'b0}, ak);
      check(ak, 1'b1);
      evt(0);
      u_tws_master.stop();
      $display("test receive done");
      s0 = m_str;
      u_tws_master.start();
      u_tws_master.wr_byte({a7, 1'b1}, ak);
      check(ak, 1'b0);
      evt(1);
      d = 8'($random(seed));
      fork
         u_tws_master.rd_byte(r, 1'b0);
         serve(1'b1, CTL_ON);
      join
      check(r, d);
      evt(1);
      d = 8'($random(seed));
      fork
         u_tws_master.rd_byte(r, 1'b1);
         serve(1'b1, CTL_ON);
      join
      check(r, d);
      evt(1);
      check(m_str, s0 + 2);
      u_tws_master.stop();
      d = 8'($random(seed));
      apb(1'b1, TWS_OFF_TX, {24'h0, d});
      u_tws_master.start();
      u_tws_master.wr_byte({a7, 1'b1}, ak);
      u_tws_master.rd_byte(r, 1'b1);
      check(r, d);
      check(m_str, s0 + 2);
      evt(2);
      u_tws_master.stop();
      $display("test transmit done");
      apb(1'b1, TWS_OFF_CTRL, CTL_STR);
      u_tws_master.start();
      u_tws_master.wr_byte({a7, 1'b0}, ak);
      evt(1);
      put();
      fork
         u_tws_master.stop();
         serve(1'b0, CTL_STR);
      join
      check(m_str, s0 + 3);
      $display("test receive stretch done");
      a10 = 10'($random(seed));
      apb(1'b1, TWS_OFF_ADDR, {22'h0, a10});
      apb(1'b1, TWS_OFF_CTRL, CTL_TEN);
      u_tws_master.start();
      u_tws_master.wr_byte({TWS_TEN_PAT, a10[9:8], 1'b0}, ak);
      check(ak, 1'b0);
      evt(1);
      stat();
      u_tws_master.wr_byte(a10[7:0], ak);
      check(ak, 1'b0);
      m_f10 = 1'b1;
      evt(1);
      stat();
      put();
      pop();
      u_tws_master.start();
      u_tws_master.wr_byte({TWS_TEN_PAT, a10[9:8], 1'b1}, ak);
      check(ak, 1'b0);
      evt(1);
      d = 8'($random(seed));
      fork
         u_tws_master.rd_byte(r, 1'b1);
         serve(1'b1, CTL_TEN);
      join
      check(r, d);
      evt(1);
      u_tws_master.stop();
      u_tws_master.start();
      u_tws_master.wr_byte({TWS_TEN_PAT, a10[9:8], 1'b0}, ak);
      m_f10 = 1'b0;
      evt(1);
      u_tws_master.wr_byte(a10[7:0] ^ 8'h01, ak);
      check(ak, 1'b1);
      evt(0);
      stat();
      u_tws_master.stop();
      check({30'h0, scl_o, sda_o}, 32'h0);
      $display("test ten-bit done");
      finish_test();
   end
endmodule
